/* design/ipt_bus_engine.sv */
// external bus access sequencer with operand priority and wait-state stretch
`timescale 1ns/100ps
`default_nettype none
module ipt_bus_engine #(
	parameter int unsigned ACC_CLKS = ipt_pkg::ACC_CLKS_DEF
) (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       req_rd,
	input  wire logic       req_wr,
	input  wire logic       req_pf,
	output logic            grant,
	output logic [1:0]      grant_kind,
	output logic            bus_start_q,
	output logic [1:0]      bus_kind_q,
	output logic            bus_busy_q,
	output logic            done
);
	import ipt_pkg::*;

	logic [7:0] cnt_q;

	// a new access may begin in the last clock of the current one
	wire free = !bus_busy_q || (cnt_q == 8'h01);
	assign done       = bus_busy_q && (cnt_q == 8'h01);
	assign grant      = free && (req_rd || req_wr || req_pf);
	// pending write first so the buffer drains, then reads, then prefetch
	assign grant_kind = req_wr ? IPT_BK_WR : (req_rd ? IPT_BK_RD : IPT_BK_PF);

	// each access lasts ACC_CLKS clocks, two on a no-wait bus
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_q       <= 8'h00;
			bus_busy_q  <= 1'b0;
			bus_start_q <= 1'b0;
			bus_kind_q  <= IPT_BK_NONE;
		end else begin
			bus_start_q <= grant;
			if (grant) begin
				cnt_q      <= 8'(ACC_CLKS);
				bus_busy_q <= 1'b1;
				bus_kind_q <= grant_kind;
			end else if (done) begin
				cnt_q      <= 8'h00;
				bus_busy_q <= 1'b0;
				bus_kind_q <= IPT_BK_NONE;
			end else if (bus_busy_q) begin
				cnt_q <= cnt_q - 8'h01;
			end
		end
	end

endmodule : ipt_bus_engine
`default_nettype wire

/* design/ipt_mode_table.sv */
// operand fetch timing lookup with long-operand adjustment
`timescale 1ns/100ps
`default_nettype none
module ipt_mode_table (
	input  wire logic [4:0] mode,
	input  wire logic       is_long,
	output logic [3:0]      head,
	output logic [4:0]      tail,
	output logic [4:0]      cycles,
	output logic [1:0]      reads,
	output logic [1:0]      fetches,
	output logic            short_ext
);
	import ipt_pkg::*;

	wire        valid_mode = (mode < 5'(NUM_MODES));
	wire [4:0]  idx        = valid_mode ? mode : 5'h00;
	wire        has_rd     = FEA_HAS_RD[idx];
	wire        add_long   = has_rd & is_long;

	// table entries; unknown codes act as a register operand
	assign head      = FEA_HEAD[idx];
	assign tail      = {1'b0, FEA_TAIL[idx]} + (add_long ? {1'b0, LONG_EXTRA} : 5'h00);
	assign cycles    = {1'b0, FEA_CYC[idx]} + (add_long ? {1'b0, LONG_EXTRA} : 5'h00);
	assign reads     = has_rd ? (is_long ? 2'h2 : 2'h1) : 2'h0;
	assign fetches   = FEA_PF[idx];
	assign short_ext = FEA_SHORT_X[idx];

endmodule : ipt_mode_table
`default_nettype wire

/* design/ipt_pkg.sv */
// constants, mode codes and operand-fetch timing tables for the prefetch timing block
package ipt_pkg;

	localparam int unsigned ACC_CLKS_DEF  = 2;  // clocks per external access
	localparam int unsigned BUS_WIDTH     = 16; // external data path in bits
	localparam logic [3:0]  LONG_EXTRA    = 4'h2; // extra clocks per long operand
	localparam logic [3:0]  BR_MIN_ACCESS = 4'h3; // least bus cycles for a branch
	localparam logic [3:0]  BR_TAKEN_DLY  = 4'h1; // displacement arrival delay
	localparam logic [3:0]  REFILL_GAP    = 4'h2; // idle clocks at change of flow
	localparam logic [1:0]  Q_MIN         = 2'h2; // words needed to start
	localparam logic [1:0]  Q_MAX         = 2'h3; // queue capacity in words
	localparam int unsigned NUM_MODES     = 23;

	// bus access kinds
	typedef enum logic [1:0] {
		IPT_BK_NONE = 2'b00,
		IPT_BK_RD   = 2'b01,
		IPT_BK_WR   = 2'b10,
		IPT_BK_PF   = 2'b11
	} ipt_kind_e;

	// operand_address modes, in table order
	typedef enum logic [4:0] {
		IPT_M_REG = 5'h00, IPT_M_IND = 5'h01, IPT_M_PINC = 5'h02, IPT_M_PDEC = 5'h03,
		IPT_M_D16 = 5'h04, IPT_M_ABSW = 5'h05, IPT_M_ABSL = 5'h06, IPT_M_IMMB = 5'h07,
		IPT_M_IMMW = 5'h08, IPT_M_IMML = 5'h09, IPT_M_IDX8 = 5'h0a, IPT_M_MSUP = 5'h0b,
		IPT_M_MD16 = 5'h0c, IPT_M_MD32 = 5'h0d, IPT_M_MAN = 5'h0e, IPT_M_MXM = 5'h0f,
		IPT_M_MANXM = 5'h10, IPT_M_MD16AN = 5'h11, IPT_M_MD32AN = 5'h12,
		IPT_M_MD16ANX = 5'h13, IPT_M_MD32ANX = 5'h14, IPT_M_MD16SC = 5'h15,
		IPT_M_MD32SC = 5'h16
	} ipt_mode_e;

	// fetch_operand_address word-access timing per mode
	localparam logic [3:0] FEA_HEAD [NUM_MODES] = '{
		4'h0, 4'h1, 4'h1, 4'h2, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h4, 4'h2,
		4'h1, 4'h1, 4'h1, 4'h4, 4'h4, 4'h1, 4'h1, 4'h2, 4'h1, 4'h2, 4'h1};
	localparam logic [3:0] FEA_TAIL [NUM_MODES] = '{
		4'h0, 4'h1, 4'h1, 4'h2, 4'h3, 4'h3, 4'h5, 4'h1, 4'h1, 4'h3, 4'h2, 4'h2,
		4'h3, 4'h5, 4'h1, 4'h2, 4'h2, 4'h3, 4'h5, 4'h2, 4'h3, 4'h2, 4'h3};
	localparam logic [3:0] FEA_CYC [NUM_MODES] = '{
		4'h0, 4'h3, 4'h3, 4'h4, 4'h5, 4'h5, 4'h7, 4'h3, 4'h3, 4'h5, 4'h8, 4'h6,
		4'h7, 4'h9, 4'h5, 4'h8, 4'h8, 4'h7, 4'h9, 4'h8, 4'h9, 4'h8, 4'h9};
	localparam logic [1:0] FEA_PF [NUM_MODES] = '{
		2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h1, 2'h1, 2'h2, 2'h1, 2'h1,
		2'h2, 2'h3, 2'h1, 2'h1, 2'h1, 2'h2, 2'h3, 2'h2, 2'h3, 2'h2, 2'h3};
	// one bit per mode: operand read present (bit = mode index)
	localparam logic [NUM_MODES-1:0] FEA_HAS_RD  = 23'h7ffc7e;
	// one bit per mode: needs a short extension word to have aged
	localparam logic [NUM_MODES-1:0] FEA_SHORT_X = 23'h0005b0;

endpackage : ipt_pkg

/* design/ipt_timing.sv */
// instruction prefetch and execution overlap timing engine
`timescale 1ns/100ps
`default_nettype none
module ipt_timing #(
	parameter int unsigned ACC_CLKS = ipt_pkg::ACC_CLKS_DEF
) (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// instruction descriptor from the sequencer
	input  wire logic       ins_valid,
	input  wire logic [4:0] ins_mode,
	input  wire logic       ins_long,
	input  wire logic [3:0] ins_op_head,
	input  wire logic [3:0] ins_op_tail,
	input  wire logic [5:0] ins_op_cycles,
	input  wire logic [1:0] ins_op_fetches,
	input  wire logic       ins_write,
	input  wire logic       ins_ext_short,
	input  wire logic       ins_branch,
	input  wire logic       ins_taken,
	output logic            ins_ready_q,
	// per-instruction report
	output logic            ins_done_q,
	output logic [7:0]      ins_clocks_q,
	output logic [1:0]      ins_reads_q,
	output logic [2:0]      ins_fetches_q,
	output logic [1:0]      ins_writes_q,
	output logic [3:0]      ins_head_q,
	output logic [4:0]      ins_tail_q,
	// queue and bus view
	output logic [1:0]      queue_words_q,
	output logic            exec_busy_q,
	output logic            bus_start_q,
	output logic [1:0]      bus_kind_q,
	output logic            bus_busy_q
);
	import ipt_pkg::*;

	typedef enum logic [1:0] {
		IPT_S_IDLE = 2'b00,
		IPT_S_WAIT = 2'b01,
		IPT_S_EXEC = 2'b10
	} ipt_state_e;

	ipt_state_e state_q;
	ipt_state_e state_d;

	// latched descriptor
	logic [4:0] mode_q;
	logic       long_q;
	logic [3:0] op_head_q;
	logic [3:0] op_tail_q;
	logic [5:0] op_cyc_q;
	logic [1:0] op_pf_q;
	logic       write_q;
	logic       ext_q;
	logic       branch_q;
	logic       taken_q;

	// run-time state
	logic [8:0] cnt_q;
	logic [7:0] clocks_q;
	logic [1:0] rd_left_q;
	logic [2:0] pf_left_q;
	logic [1:0] wr_left_q;
	logic [4:0] prev_tail_q;
	logic       br_inhibit_q;
	logic       flushed_q;
	logic       ext_aged_q;

	// operand_address timing of the latched mode
	logic [3:0] ea_head;
	logic [4:0] ea_tail;
	logic [4:0] ea_cyc;
	logic [1:0] ea_rd;
	logic [1:0] ea_pf;
	logic       ea_short;

	ipt_mode_table u_table (
		.mode      (mode_q),
		.is_long   (long_q),
		.head      (ea_head),
		.tail      (ea_tail),
		.cycles    (ea_cyc),
		.reads     (ea_rd),
		.fetches   (ea_pf),
		.short_ext (ea_short)
	);

	// bus requests and grants
	logic       grant;
	logic [1:0] grant_kind;
	logic       bus_done;

	wire pf_inflight = bus_busy_q && (bus_kind_q == IPT_BK_PF);
	wire pf_done     = bus_done && (bus_kind_q == IPT_BK_PF);
	wire [2:0] q_fill = {1'b0, queue_words_q} + {2'b00, pf_inflight};
	wire room        = (q_fill < {1'b0, Q_MAX});
	wire req_rd      = (state_q == IPT_S_EXEC) && (rd_left_q != 2'h0);
	wire req_wr      = (wr_left_q != 2'h0);
	// own fetches run from the start of address calculation
	wire req_own     = (state_q == IPT_S_EXEC) && (pf_left_q != 3'h0);
	// spare slots top the queue up, except along a branch's old path
	wire req_extra   = room && !br_inhibit_q;
	wire req_pf      = (req_own || req_extra) && room;
	wire g_rd        = grant && (grant_kind == IPT_BK_RD);
	wire g_wr        = grant && (grant_kind == IPT_BK_WR);
	wire g_pf        = grant && (grant_kind == IPT_BK_PF);

	ipt_bus_engine #(
		.ACC_CLKS (ACC_CLKS)
	) u_bus (
		.clk         (clk),
		.sys_rst     (sys_rst),
		.req_rd      (req_rd),
		.req_wr      (req_wr),
		.req_pf      (req_pf),
		.grant       (grant),
		.grant_kind  (grant_kind),
		.bus_start_q (bus_start_q),
		.bus_kind_q  (bus_kind_q),
		.bus_busy_q  (bus_busy_q),
		.done        (bus_done)
	);

	// start condition: enough words, extension word aged one cycle
	wire need_ext  = (ea_short || ext_q);
	wire can_start = (queue_words_q >= Q_MIN) && (!need_ext || ext_aged_q);

	// overlap between the prior write and this head, and inside the instruction
	wire [4:0] head5     = {1'b0, ea_head};
	wire [4:0] ophead5   = {1'b0, op_head_q};
	wire [4:0] save_prev = (prev_tail_q < head5) ? prev_tail_q : head5;
	// a zero operation head takes none of the read time in the tail
	wire [4:0] save_ea   = (ea_tail < ophead5) ? ea_tail : ophead5;
	wire [2:0] n_acc     = {1'b0, ea_rd} + {1'b0, ea_pf};
	wire [8:0] stretch   = 9'(n_acc) * 9'(ACC_CLKS - 2);
	wire [8:0] base_cnt  = 9'(ea_cyc) + 9'(op_cyc_q) + stretch
	                     - 9'(save_ea) - 9'(save_prev);
	wire [8:0] br_min    = 9'(BR_MIN_ACCESS) * 9'(ACC_CLKS);
	wire [8:0] br_cnt    = ((base_cnt < br_min) ? br_min : base_cnt)
	                     + (taken_q ? 9'(BR_TAKEN_DLY) : 9'h000);
	wire [8:0] load_raw  = branch_q ? br_cnt : base_cnt;
	wire [8:0] load_cnt  = (load_raw == 9'h000) ? 9'h001 : load_raw;

	// opword and extension words leave at start, at least the fetches back but never more than the queue holds
	wire [2:0] own_w     = {1'b0, ea_pf} + {1'b0, op_pf_q};
	wire [2:0] need_w    = (own_w > (3'h1 + {1'b0, ea_pf})) ? own_w : (3'h1 + {1'b0, ea_pf});
	wire [2:0] consume   = (need_w > {1'b0, queue_words_q}) ? {1'b0, queue_words_q} : need_w;
	wire       start     = (state_q == IPT_S_WAIT) && can_start && (rd_left_q == 2'h0);
	// old path words are dropped as the refill gap opens
	wire       flush_now = (state_q == IPT_S_EXEC) && branch_q && taken_q && !flushed_q
	                     && (cnt_q <= 9'(REFILL_GAP));
	// the end waits for own fetches and reads and, for a writing instruction, a free write buffer
	wire       end_ok    = (state_q == IPT_S_EXEC) && (cnt_q <= 9'h001) && (rd_left_q == 2'h0)
	                     && (pf_left_q == 3'h0) && !(write_q && req_wr);
	wire [2:0] q_after   = {1'b0, queue_words_q} - (start ? consume : 3'h0)
	                     + {2'b00, pf_done};
	wire [1:0] q_next    = flush_now ? 2'h0 : ((q_after > 3'(Q_MAX)) ? Q_MAX : q_after[1:0]);

	// state sequencing
	always_comb begin
		state_d = state_q;
		case (state_q)
			IPT_S_IDLE: begin
				if (ins_valid) begin
					state_d = IPT_S_WAIT;
				end
			end
			IPT_S_WAIT: begin
				if (start) begin
					state_d = IPT_S_EXEC;
				end
			end
			IPT_S_EXEC: begin
				if (end_ok) begin
					state_d = IPT_S_IDLE;
				end
			end
			default: state_d = IPT_S_IDLE;
		endcase
	end

	// descriptor capture when the sequencer offers an instruction
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			{mode_q, long_q, op_head_q, op_tail_q, op_cyc_q} <= '0;
			{op_pf_q, write_q, ext_q, branch_q, taken_q}    <= '0;
		end else if (ins_ready_q && ins_valid) begin
			mode_q    <= ins_mode;
			long_q    <= ins_long;
			op_head_q <= ins_op_head;
			op_tail_q <= ins_op_tail;
			op_cyc_q  <= ins_op_cycles;
			op_pf_q   <= ins_op_fetches;
			write_q   <= ins_write;
			ext_q     <= ins_ext_short;
			branch_q  <= ins_branch;
			taken_q   <= ins_taken && ins_branch;
		end
	end

	// state, queue level and extension aging
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q       <= IPT_S_IDLE;
			ins_ready_q   <= 1'b1;
			exec_busy_q   <= 1'b0;
			queue_words_q <= Q_MIN;
			ext_aged_q    <= 1'b0;
		end else begin
			state_q       <= state_d;
			ins_ready_q   <= (state_d == IPT_S_IDLE);
			exec_busy_q   <= (state_d == IPT_S_EXEC);
			queue_words_q <= q_next;
			ext_aged_q    <= (queue_words_q >= Q_MIN) && !flush_now;
		end
	end

	// execution clock count and outstanding operand and fetch work
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_q     <= 9'h000;
			clocks_q  <= 8'h00;
			rd_left_q <= 2'h0;
			pf_left_q <= 3'h0;
		end else if (start) begin
			cnt_q     <= load_cnt;
			clocks_q  <= 8'h01;
			rd_left_q <= ea_rd;
			pf_left_q <= {1'b0, ea_pf} + {1'b0, op_pf_q};
		end else begin
			if (state_q == IPT_S_EXEC) begin
				cnt_q    <= (cnt_q > 9'h001) ? cnt_q - 9'h001 : cnt_q;
				clocks_q <= clocks_q + 8'h01;
			end
			if (g_rd) begin
				rd_left_q <= rd_left_q - 2'h1;
			end
			if (g_pf && (pf_left_q != 3'h0)) begin
				pf_left_q <= pf_left_q - 3'h1;
			end
		end
	end

	// branch path control: no sequential prefetch until the flush, or until the end of an untaken branch
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			br_inhibit_q <= 1'b0;
			flushed_q    <= 1'b0;
		end else if (start) begin
			br_inhibit_q <= branch_q;
			flushed_q    <= 1'b0;
		end else if (flush_now) begin
			br_inhibit_q <= 1'b0;
			flushed_q    <= 1'b1;
		end else if (end_ok) begin
			br_inhibit_q <= 1'b0;
		end
	end

	// write pending buffer: queued at the end, drains under the next head
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_left_q   <= 2'h0;
			prev_tail_q <= 5'h00;
		end else if (end_ok && write_q) begin
			wr_left_q   <= long_q ? 2'h2 : 2'h1;
			prev_tail_q <= {1'b0, op_tail_q} + (long_q ? {1'b0, LONG_EXTRA} : 5'h00);
		end else begin
			if (g_wr) begin
				wr_left_q <= wr_left_q - 2'h1;
			end
			if (start) begin
				prev_tail_q <= 5'h00;
			end
		end
	end

	// per-instruction report on completion
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ins_done_q    <= 1'b0;
			ins_clocks_q  <= 8'h00;
			ins_reads_q   <= 2'h0;
			ins_fetches_q <= 3'h0;
			ins_writes_q  <= 2'h0;
			ins_head_q    <= 4'h0;
			ins_tail_q    <= 5'h00;
		end else begin
			ins_done_q <= end_ok;
			if (end_ok) begin
				ins_clocks_q  <= clocks_q;
				ins_reads_q   <= ea_rd;
				ins_fetches_q <= {1'b0, ea_pf} + {1'b0, op_pf_q};
				ins_writes_q  <= write_q ? (long_q ? 2'h2 : 2'h1) : 2'h0;
				ins_head_q    <= ea_head;
				ins_tail_q    <= write_q ? {1'b0, op_tail_q} : 5'h00;
			end
		end
	end

endmodule : ipt_timing
`default_nettype wire

/* dv/ipt_mem_model.sv */
// zero-wait synchronous memory seen through the bus view, counting accesses
`timescale 1ns/100ps
`default_nettype none
module ipt_mem_model (
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic       bus_start_q,
	input wire logic [1:0] bus_kind_q
);
	int rd_cnt;
	int wr_cnt;
	int pf_cnt;
	// every access is answered in its nominal clocks; only the kinds are tallied
	always @(posedge clk) begin
		if (sys_rst) begin
			rd_cnt <= 0;
			wr_cnt <= 0;
			pf_cnt <= 0;
		end else if (bus_start_q) begin
			if (bus_kind_q == 2'h1) rd_cnt <= rd_cnt + 1;
			if (bus_kind_q == 2'h2) wr_cnt <= wr_cnt + 1;
			if (bus_kind_q == 2'h3) pf_cnt <= pf_cnt + 1;
		end
	end
endmodule : ipt_mem_model
`default_nettype wire

/* dv/ipt_timing_props.sv */
// assertion checker for the prefetch timing block
`timescale 1ns/100ps
`default_nettype none
module ipt_timing_props
	import ipt_pkg::*;
#(
	parameter int unsigned ACC_CLKS = ACC_CLKS_DEF
) (
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic       ins_valid,
	input wire logic       ins_branch,
	input wire logic       ins_taken,
	input wire logic       ins_ready_q,
	input wire logic       ins_done_q,
	input wire logic [1:0] queue_words_q,
	input wire logic       exec_busy_q,
	input wire logic       bus_start_q,
	input wire logic [1:0] bus_kind_q,
	input wire logic       bus_busy_q
);
	logic [3:0] acc_q;
	logic [3:0] acc_idx;
	logic       take;
	// clock index within the current bus access
	assign acc_idx = bus_start_q ? 4'h1 : acc_q + 4'h1;
	assign take    = ins_valid && ins_ready_q;
	always_ff @(posedge clk) begin
		acc_q <= (sys_rst || !bus_busy_q) ? 4'h0 : acc_idx;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_acc_hold;
		bus_busy_q && acc_idx < ACC_CLKS |=> bus_busy_q && !bus_start_q;
	endproperty
	a_acc_hold: assert property (p_acc_hold) else $error("bus access ended early");
	property p_acc_end;
		bus_busy_q && acc_idx >= ACC_CLKS |=> !bus_busy_q || bus_start_q;
	endproperty
	a_acc_end: assert property (p_acc_end) else $error("bus access too long");
	property p_kind_hold;
		bus_busy_q && !bus_start_q |-> $stable(bus_kind_q);
	endproperty
	a_kind_hold: assert property (p_kind_hold) else $error("access kind changed");
	property p_kind_set;
		bus_busy_q |-> bus_kind_q != IPT_BK_NONE;
	endproperty
	a_kind_set: assert property (p_kind_set) else $error("busy bus with no kind");
	property p_q_start;
		$rose(exec_busy_q) |-> $past(queue_words_q) >= Q_MIN;
	endproperty
	a_q_start: assert property (p_q_start) else $error("start with short queue");
	property p_done_pulse;
		ins_done_q |=> !ins_done_q;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");
	property p_done_idle;
		ins_done_q |-> ins_ready_q && !exec_busy_q;
	endproperty
	a_done_idle: assert property (p_done_idle) else $error("done while busy");
	property p_min_lat;
		take |=> !ins_done_q [*2];
	endproperty
	a_min_lat: assert property (p_min_lat) else $error("done too soon");
	property p_br_min;
		take && ins_branch |=> !ins_done_q [*6];
	endproperty
	a_br_min: assert property (p_br_min) else $error("branch too short");
	property p_br_taken;
		take && ins_branch && ins_taken |=> !ins_done_q [*7];
	endproperty
	a_br_taken: assert property (p_br_taken) else $error("taken branch too short");
endmodule : ipt_timing_props
bind ipt_timing ipt_timing_props #(.ACC_CLKS(ACC_CLKS)) ipt_timing_props_inst (
	.clk(clk), .sys_rst(sys_rst), .ins_valid(ins_valid), .ins_branch(ins_branch),
	.ins_taken(ins_taken), .ins_ready_q(ins_ready_q), .ins_done_q(ins_done_q),
	.queue_words_q(queue_words_q), .exec_busy_q(exec_busy_q), .bus_start_q(bus_start_q),
	.bus_kind_q(bus_kind_q), .bus_busy_q(bus_busy_q));
`default_nettype wire

/* dv/tb_ipt_timing.sv */
// self-checking bench for the prefetch timing block
`timescale 1ns/100ps
`default_nettype none
module tb_ipt_timing;
	import ipt_pkg::*;
	logic clk, sys_rst, ins_valid, ins_long, ins_write, ins_ext_short, ins_branch, ins_taken;
	logic [4:0] ins_mode;
	logic [3:0] ins_op_head, ins_op_tail, ins_head_q;
	logic [5:0] ins_op_cycles;
	logic [1:0] ins_op_fetches, ins_reads_q, ins_writes_q, queue_words_q, bus_kind_q;
	logic       ins_ready_q, ins_done_q, exec_busy_q, bus_start_q, bus_busy_q;
	logic [7:0] ins_clocks_q;
	logic [2:0] ins_fetches_q;
	logic [4:0] ins_tail_q;
	int err_total, total_checks;
	ipt_timing #(.ACC_CLKS(2)) ipt_timing_inst (.clk(clk), .sys_rst(sys_rst),
		.ins_valid(ins_valid), .ins_mode(ins_mode), .ins_long(ins_long),
		.ins_op_head(ins_op_head), .ins_op_tail(ins_op_tail), .ins_op_cycles(ins_op_cycles),
		.ins_op_fetches(ins_op_fetches), .ins_write(ins_write), .ins_ext_short(ins_ext_short),
		.ins_branch(ins_branch), .ins_taken(ins_taken), .ins_ready_q(ins_ready_q),
		.ins_done_q(ins_done_q), .ins_clocks_q(ins_clocks_q), .ins_reads_q(ins_reads_q),
		.ins_fetches_q(ins_fetches_q), .ins_writes_q(ins_writes_q), .ins_head_q(ins_head_q),
		.ins_tail_q(ins_tail_q), .queue_words_q(queue_words_q), .exec_busy_q(exec_busy_q),
		.bus_start_q(bus_start_q), .bus_kind_q(bus_kind_q), .bus_busy_q(bus_busy_q));
	ipt_mem_model ipt_mem_model_inst (.clk(clk), .sys_rst(sys_rst),
		.bus_start_q(bus_start_q), .bus_kind_q(bus_kind_q));
	// verdict and end of run
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	// exact comparison
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			$display("Error %s expected %0h seen %0h", nm, exp, got);
			err_total++;
		end
	endtask : chk
	// lower-bound comparison
	task automatic chk_min(input string nm, input logic [7:0] lo, input logic [7:0] got);
		total_checks++;
		if ((^got === 1'bx) || got < lo) begin
			$display("Error %s expected at least %0h seen %0h", nm, lo, got);
			err_total++;
		end
	endtask : chk_min
	// offer one descriptor and wait for its completion report
	task automatic issue(input logic [4:0] m, input logic lg, input logic [3:0] hd, tl,
		input logic [5:0] cy, input logic [1:0] pf, input logic wr, ex, br, tk);
		int n;
		for (n = 0; n < 60 && ins_ready_q !== 1'b1; n++) @(negedge clk);
		if (n == 60) begin
			err_total++;
			close_out();
		end
		{ins_mode, ins_long, ins_op_head, ins_op_tail} = {m, lg, hd, tl};
		{ins_op_cycles, ins_op_fetches, ins_write} = {cy, pf, wr};
		{ins_ext_short, ins_branch, ins_taken, ins_valid} = {ex, br, tk, 1'b1};
		@(negedge clk);
		ins_valid = 1'b0;
		for (n = 0; n < 200 && ins_done_q !== 1'b1; n++) @(negedge clk);
		if (n == 200) begin
			err_total++;
			close_out();
		end
	endtask : issue
	// state after reset and prefetch to a full queue
	task automatic t_reset();
		int n;
		chk("ready", 8'h1, 8'(ins_ready_q));
		chk("queue", 8'h2, 8'(queue_words_q));
		chk("busy", 8'h0, 8'(bus_busy_q));
		for (n = 0; n < 20 && queue_words_q !== Q_MAX; n++) @(negedge clk);
		chk("queue full", 8'h3, 8'(queue_words_q));
		$display("test reset done");
	endtask : t_reset
	// operand fetch timing per addressing mode
	task automatic t_modes();
		logic [4:0] md [10] = '{IPT_M_IND, IPT_M_PDEC, IPT_M_IDX8, IPT_M_ABSW, IPT_M_ABSL,
			IPT_M_IMMW, IPT_M_IMML, IPT_M_MSUP, IPT_M_MD32, IPT_M_IND};
		logic [7:0] hd [10] = '{1, 2, 4, 1, 1, 1, 1, 2, 1, 1};
		logic [7:0] cy [10] = '{3, 4, 8, 5, 7, 3, 5, 6, 9, 5};
		logic [7:0] pf [10] = '{0, 0, 1, 1, 2, 1, 2, 1, 3, 0};
		logic [7:0] rd [10] = '{1, 1, 1, 1, 1, 0, 0, 1, 1, 2};
		int r0;
		for (int i = 0; i < 10; i++) begin
			r0 = ipt_mem_model_inst.rd_cnt;
			issue(md[i], i == 9, 4'h0, 4'h0, 6'h0, 2'h0, 1'b0, i == 3, 1'b0, 1'b0);
			chk("reads", rd[i], 8'(ins_reads_q));
			chk("bus reads", rd[i], 8'(ipt_mem_model_inst.rd_cnt - r0));
			chk("fetches", pf[i], 8'(ins_fetches_q));
			chk("head", hd[i], 8'(ins_head_q));
			chk_min("clocks", cy[i], ins_clocks_q);
		end
		$display("test modes done");
	endtask : t_modes
	// branch not taken and taken
	task automatic t_branch();
		issue(IPT_M_REG, 1'b0, 4'h0, 4'h0, 6'h2, 2'h2, 1'b0, 1'b0, 1'b1, 1'b0);
		chk("br fetches", 8'h2, 8'(ins_fetches_q));
		chk_min("br clocks", 8'h6, ins_clocks_q);
		issue(IPT_M_REG, 1'b0, 4'h0, 4'h0, 6'h2, 2'h2, 1'b0, 1'b0, 1'b1, 1'b1);
		chk_min("taken clocks", 8'h7, ins_clocks_q);
		$display("test branch done");
	endtask : t_branch
	// trailing write overlapping the next head
	task automatic t_write();
		int w0;
		w0 = ipt_mem_model_inst.wr_cnt;
		issue(IPT_M_REG, 1'b0, 4'h0, 4'h2, 6'h4, 2'h1, 1'b1, 1'b0, 1'b0, 1'b0);
		chk("writes", 8'h1, 8'(ins_writes_q));
		chk("tail", 8'h2, 8'(ins_tail_q));
		issue(IPT_M_PDEC, 1'b0, 4'h0, 4'h0, 6'h0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
		chk("writes2", 8'h0, 8'(ins_writes_q));
		chk_min("clocks2", 8'h2, ins_clocks_q);
		chk("bus writes", 8'h1, 8'(ipt_mem_model_inst.wr_cnt - w0));
		$display("test write done");
	endtask : t_write
	// clock source
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// main sequence
	initial begin
		{sys_rst, ins_valid, ins_long, ins_write, ins_ext_short} = 5'b10000;
		{ins_branch, ins_taken, ins_mode, ins_op_head, ins_op_tail} = '0;
		{ins_op_cycles, ins_op_fetches} = '0;
		err_total = 0;
		total_checks = 0;
		repeat (8) @(negedge clk);
		sys_rst = 1'b0;
		t_reset();
		t_modes();
		t_branch();
		t_write();
		close_out();
	end
endmodule : tb_ipt_timing
`default_nettype wire
